// ===== hdl/pwt_pkg.sv
// constants, types and helpers shared by the periodic pwm timer channel
// Functional notes
// - periodic, one-shot or pwm mode; periodic after reset
// - auto start runs on configure, else waits start
// - output a carries waveform only when enabled
// - stopped pin sits low, high or retained
// - output b has own enable and stop level
// - every period expiry raises an interrupt event
// - enabled output starts at stop level, toggles on expiry in all modes but pwm
// - one-shot also toggles at start, giving one pulse if stopped at expiry
// - count clock divided by prescaler up to 1024
package pwt_pkg;

    localparam int          PWT_ADDR_W      = 8;
    localparam logic [7:0]  PWT_OFF_CTRL    = 8'h00;
    localparam logic [7:0]  PWT_OFF_CMD     = 8'h04;
    localparam logic [7:0]  PWT_OFF_PERIOD  = 8'h08;
    localparam logic [7:0]  PWT_OFF_DUTY    = 8'h0C;
    localparam logic [7:0]  PWT_OFF_COUNT   = 8'h10;
    localparam logic [7:0]  PWT_OFF_STATUS  = 8'h14;
    localparam logic [7:0]  PWT_OFF_MASK    = 8'h18;

    localparam logic [31:0] PWT_CTRL_WMASK  = 32'h0000_1FFF;
    localparam logic [31:0] PWT_CTRL_RST    = 32'h0000_0004;
    localparam int          PWT_CMD_START   = 0;
    localparam int          PWT_CMD_STOP    = 1;
    localparam int          PWT_STS_EXP     = 0;
    localparam int          PWT_STS_RUN     = 1;
    localparam int          PWT_MASK_EXP    = 0;
    localparam logic [1:0]  PWT_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  PWT_RESP_SLVERR = 2'h2;

    localparam int          PWT_PRESC_W     = 10;
    localparam logic [3:0]  PWT_PRESC_MAX   = 4'hA;

    typedef struct packed {
        logic [18:0] rsvd;
        logic [3:0]  presc;
        logic [1:0]  stop_b;
        logic        en_b;
        logic [1:0]  stop_a;
        logic        en_a;
        logic        auto_start;
        logic [1:0]  mode;
    } pwt_ctrl_t;

    typedef enum logic [1:0] {
        PWT_MODE_PERIODIC = 2'h0,
        PWT_MODE_ONESHOT  = 2'h1,
        PWT_MODE_PWM      = 2'h2
    } pwt_mode_t;

    typedef enum logic [1:0] {
        PWT_STOP_LOW  = 2'h0,
        PWT_STOP_HIGH = 2'h1,
        PWT_STOP_KEEP = 2'h2
    } pwt_stop_t;

    typedef enum logic [1:0] {
        PWT_ST_STOP = 2'b01,
        PWT_ST_RUN  = 2'b10
    } pwt_run_t;

    function automatic logic [31:0] pwt_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [PWT_PRESC_W-1:0] pwt_presc_limit(input logic [3:0] sel);
        logic [3:0]           s;
        logic [PWT_PRESC_W:0] full;
        s = (sel > PWT_PRESC_MAX) ? PWT_PRESC_MAX : sel;
        full = (11'h001 << s) - 11'h001;
        return full[PWT_PRESC_W-1:0];
    endfunction

endpackage

// ===== hdl/pwt_link_if.sv
// signals shared between the timer core, its prescaler and its pin drivers
`timescale 1ns/100ps
`default_nettype none
interface pwt_link_if;
    import pwt_pkg::*;
    logic        tick;
    logic        running;
    logic        start_pulse;
    logic        expiry;
    pwt_mode_t   mode;
    logic [31:0] count;
    logic [31:0] duty;
    logic [3:0]  presc;
    modport core (input tick, output running, start_pulse, expiry, mode, count, duty, presc);
    modport pre  (input running, presc, output tick);
    modport pin  (input running, start_pulse, expiry, mode, count, duty);
endinterface
`default_nettype wire

// ===== hdl/pwt_prescaler.sv
// count-clock divider: one tick every 2**presc peripheral clocks, presc clamped at 10
`timescale 1ns/100ps
`default_nettype none
module pwt_prescaler
    import pwt_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    pwt_link_if.pre   lk
);
    typedef struct packed {
        logic [PWT_PRESC_W-1:0] cnt;
    } pwt_pre_state_t;

    pwt_pre_state_t         r;
    pwt_pre_state_t         n;
    logic [PWT_PRESC_W-1:0] limit;
    logic                   tick;

    assign limit   = pwt_presc_limit(lk.presc);
    // at or above the limit, so lowering the divider mid-run cannot stall for a wrap
    assign tick    = lk.running && (r.cnt >= limit);
    assign lk.tick = tick;

    // cleared while stopped so every start sees a full first division
    always_comb begin
        n = r;
        if (!lk.running || tick) begin
            n.cnt = '0;
        end else begin
            n.cnt = r.cnt + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    a_presc_max_gap: assert property (@(posedge aclk) disable iff (!aresetn)
        tick && (lk.presc >= PWT_PRESC_MAX) |=> !tick [*8])
        else $error("prescaler ticked too soon at divide by 1024");

endmodule
`default_nettype wire

// ===== hdl/pwt_pin_drv.sv
// one timer output pin: stop level, toggle on expiry, one-shot pulse, pwm
`timescale 1ns/100ps
`default_nettype none
module pwt_pin_drv
    import pwt_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    pwt_link_if.pin         lk,
    input  wire logic       en,
    input  wire logic [1:0] stop,
    output logic            pin_out
);
    typedef struct packed {
        logic level;
        logic pin;
    } pwt_pin_state_t;

    pwt_pin_state_t r;
    pwt_pin_state_t n;
    logic           base;

    always_comb begin
        n = r;
        case (pwt_stop_t'(stop))
            PWT_STOP_HIGH: base = 1'b1;
            PWT_STOP_KEEP: base = r.level;
            default:       base = 1'b0;
        endcase
        if (lk.start_pulse) begin
            n.level = (lk.mode == PWT_MODE_ONESHOT) ? ~base : base;
        end else if (!lk.running) begin
            n.level = base;
        end else if (lk.mode == PWT_MODE_PWM) begin
            n.level = (lk.count < lk.duty);
        end else if (lk.expiry) begin
            n.level = ~r.level;
        end
        n.pin = en ? n.level : 1'b0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign pin_out = r.pin;

    a_pin_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
        !en |=> !pin_out)
        else $error("disabled pin shows timer waveform");
    a_stop_low: assert property (@(posedge aclk) disable iff (!aresetn)
        !lk.running && !lk.start_pulse && en && (stop == PWT_STOP_LOW) |=> !pin_out)
        else $error("stopped pin not at low stop level");
    a_expiry_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
        lk.running && en && lk.expiry && (lk.mode != PWT_MODE_PWM)
        |=> pin_out == !$past(r.level))
        else $error("pin did not toggle on expiry");
    a_oneshot_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
        lk.start_pulse && en && (lk.mode == PWT_MODE_ONESHOT) && (stop == PWT_STOP_LOW)
        |=> pin_out ##1 (pin_out || !lk.running || lk.expiry))
        else $error("one-shot start did not raise the pin");
    a_pwm_duty: assert property (@(posedge aclk) disable iff (!aresetn)
        lk.running && !lk.start_pulse && en && (lk.mode == PWT_MODE_PWM)
        |=> pin_out == ($past(lk.count) < $past(lk.duty)))
        else $error("pwm level disagrees with duty compare");

endmodule
`default_nettype wire

// ===== hdl/pwt_timer.sv
// periodic pwm timer channel: axi4-lite registers, counter, interrupt, pins
`timescale 1ns/100ps
`default_nettype none
module pwt_timer
    import pwt_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [PWT_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [PWT_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic                       irq,
    output logic                       timer_output_pin_a,
    output logic                       timer_output_pin_b
);
    typedef struct packed {
        logic                  aw_held;
        logic [PWT_ADDR_W-1:0] awaddr;
        logic                  w_held;
        logic [31:0]           wdata;
        logic [3:0]            wstrb;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
        pwt_ctrl_t             ctrl;
        logic [31:0]           period;
        logic [31:0]           duty;
        logic [31:0]           count;
        logic                  sts_exp;
        logic                  mask_exp;
        pwt_run_t              run;
    } pwt_top_state_t;

    localparam pwt_top_state_t PWT_TOP_RST = '{
        ctrl:    pwt_ctrl_t'(PWT_CTRL_RST),
        run:     PWT_ST_STOP,
        bresp:   PWT_RESP_OKAY,
        rresp:   PWT_RESP_OKAY,
        default: '0
    };

    pwt_top_state_t r;
    pwt_top_state_t n;
    pwt_link_if     lk ();

    logic        do_wr;
    logic        ctrl_wr;
    logic        cmd_start;
    logic        cmd_stop;
    logic        sts_clr;
    logic        start_req;
    logic        running;
    logic        expiry;
    logic [31:0] rd;
    logic [1:0]  pin_en;
    logic [1:0]  pin_stop [2];
    logic [1:0]  pin_q;

    assign running = (r.run == PWT_ST_RUN);
    // expiry is the tick on which the count has reached the period value
    assign expiry  = running && lk.tick && (r.count == r.period);

    // writes wait until both address and data are held and no response is pending
    assign do_wr         = r.aw_held && r.w_held && !r.bvalid;
    assign s_axi_awready = !r.aw_held;
    assign s_axi_wready  = !r.w_held;
    assign s_axi_arready = !r.rvalid;

    always_comb begin
        n         = r;
        ctrl_wr   = 1'b0;
        cmd_start = 1'b0;
        cmd_stop  = 1'b0;
        sts_clr   = 1'b0;
        rd        = '0;
        start_req = 1'b0;

        if (s_axi_awvalid && s_axi_awready) begin
            n.aw_held = 1'b1;
            n.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            n.w_held = 1'b1;
            n.wdata  = s_axi_wdata;
            n.wstrb  = s_axi_wstrb;
        end
        if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end

        if (do_wr) begin
            n.aw_held = 1'b0;
            n.w_held  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = PWT_RESP_OKAY;
            case (r.awaddr)
                PWT_OFF_CTRL: begin
                    n.ctrl  = pwt_ctrl_t'(pwt_merge(r.ctrl, r.wdata, r.wstrb)
                                          & PWT_CTRL_WMASK);
                    ctrl_wr = 1'b1;
                end
                PWT_OFF_CMD: begin
                    cmd_start = r.wstrb[0] && r.wdata[PWT_CMD_START];
                    cmd_stop  = r.wstrb[0] && r.wdata[PWT_CMD_STOP];
                end
                PWT_OFF_PERIOD: begin
                    n.period = pwt_merge(r.period, r.wdata, r.wstrb);
                end
                PWT_OFF_DUTY: begin
                    n.duty = pwt_merge(r.duty, r.wdata, r.wstrb);
                end
                PWT_OFF_COUNT: begin
                    n.bresp = PWT_RESP_OKAY;
                end
                PWT_OFF_STATUS: begin
                    sts_clr = r.wstrb[0] && r.wdata[PWT_STS_EXP];
                end
                PWT_OFF_MASK: begin
                    if (r.wstrb[0]) begin
                        n.mask_exp = r.wdata[PWT_MASK_EXP];
                    end
                end
                default: begin
                    n.bresp = PWT_RESP_SLVERR;
                end
            endcase
        end

        if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            n.rvalid = 1'b1;
            n.rresp  = PWT_RESP_OKAY;
            case (s_axi_araddr)
                PWT_OFF_CTRL:   rd = r.ctrl;
                PWT_OFF_CMD:    rd = '0;
                PWT_OFF_PERIOD: rd = r.period;
                PWT_OFF_DUTY:   rd = r.duty;
                PWT_OFF_COUNT:  rd = r.count;
                PWT_OFF_STATUS: begin
                    rd[PWT_STS_EXP] = r.sts_exp;
                    rd[PWT_STS_RUN] = running;
                end
                PWT_OFF_MASK: begin
                    rd[PWT_MASK_EXP] = r.mask_exp;
                end
                default: begin
                    n.rresp = PWT_RESP_SLVERR;
                end
            endcase
            n.rdata = rd;
        end

        // a new configuration with auto start set begins counting at once
        start_req = cmd_start || (ctrl_wr && n.ctrl.auto_start);

        case (r.run)
            PWT_ST_STOP: begin
                if (start_req && !cmd_stop) begin
                    n.run   = PWT_ST_RUN;
                    n.count = '0;
                end
            end
            PWT_ST_RUN: begin
                // one-shot relies on software stopping from the expiry handler
                if (cmd_stop) begin
                    n.run = PWT_ST_STOP;
                end
                if (lk.tick) begin
                    n.count = (r.count == r.period) ? '0 : r.count + 32'h0000_0001;
                end
            end
            default: begin
                n.run = PWT_ST_STOP;
            end
        endcase

        // an expiry in the clearing cycle wins so no event is lost
        n.sts_exp = (r.sts_exp && !sts_clr) || expiry;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= PWT_TOP_RST;
        end else begin
            r <= n;
        end
    end

    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp  = r.bresp;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata  = r.rdata;
    assign s_axi_rresp  = r.rresp;
    assign irq          = r.sts_exp && r.mask_exp;

    assign lk.running     = running;
    assign lk.start_pulse = (r.run == PWT_ST_STOP) && (n.run == PWT_ST_RUN);
    assign lk.expiry      = expiry;
    assign lk.mode        = pwt_mode_t'(r.ctrl.mode);
    assign lk.count       = r.count;
    assign lk.duty        = r.duty;
    assign lk.presc       = r.ctrl.presc;

    pwt_prescaler u_presc (
        .aclk    (aclk),
        .aresetn (aresetn),
        .lk      (lk.pre)
    );

    // each pin has its own enable and stop level
    assign pin_en      = {r.ctrl.en_b, r.ctrl.en_a};
    assign pin_stop[0] = r.ctrl.stop_a;
    assign pin_stop[1] = r.ctrl.stop_b;

    for (genvar g = 0; g < 2; g++) begin : g_pin
        pwt_pin_drv u_pin (
            .aclk    (aclk),
            .aresetn (aresetn),
            .lk      (lk.pin),
            .en      (pin_en[g]),
            .stop    (pin_stop[g]),
            .pin_out (pin_q[g])
        );
    end

    assign timer_output_pin_a = pin_q[0];
    assign timer_output_pin_b = pin_q[1];

    a_reset_mode: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> (r.ctrl.mode == PWT_MODE_PERIODIC) && !r.ctrl.en_a)
        else $error("mode after reset is not periodic");
    a_auto_start: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_wr && n.ctrl.auto_start && !running |=> running && (r.count == 32'h0))
        else $error("auto start did not start the counter");
    a_stay_stopped: assert property (@(posedge aclk) disable iff (!aresetn)
        !running && !cmd_start && !ctrl_wr |=> !running)
        else $error("counter started without a start request");
    a_expiry_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        expiry ##1 r.mask_exp |-> irq)
        else $error("expiry did not raise the interrupt");
    a_count_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        running && lk.tick && (r.count == r.period) && !cmd_stop |=> (r.count == 32'h0))
        else $error("count did not wrap at the period");
    a_start_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
        cmd_start && !cmd_stop && !running |=> running && (r.count == 32'h0))
        else $error("start command did not start the counter");
    a_stop_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
        cmd_stop |=> !running)
        else $error("stop command did not stop the counter");
    a_sts_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        sts_clr && !expiry |=> !r.sts_exp)
        else $error("expired flag not cleared by write one");
    a_sts_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
        expiry |=> r.sts_exp)
        else $error("expiry did not set the expired flag");
    a_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
        running && !lk.tick |=> $stable(r.count))
        else $error("count moved without a prescaler tick");
    a_presc_unit: assert property (@(posedge aclk) disable iff (!aresetn)
        running && (lk.presc == 4'h0) |-> lk.tick)
        else $error("undivided count clock missed a tick");
    a_pins_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> !timer_output_pin_a && !timer_output_pin_b)
        else $error("output pins not low after reset");

    // bus answers must stand until the master takes them
    a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    a_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data changed before rready");

endmodule
`default_nettype wire

// ===== dv/pwt_pin_mon.sv
// far-side model of the circuit on one timer pin: measures toggle spacing and high time
`timescale 1ns/100ps
`default_nettype none
module pwt_pin_mon (
    input  wire logic        aclk,
    input  wire logic        pin,
    input  wire logic        clr,
    output logic      [31:0] gap,
    output logic      [31:0] high_cnt
);
    logic        last;
    logic [31:0] since;

    initial begin
        last     = 1'b0;
        since    = 32'h0;
        gap      = 32'h0;
        high_cnt = 32'h0;
    end

    // gap is the number of clock edges between the two latest level changes
    always @(posedge aclk) begin
        if (clr) begin
            high_cnt <= 32'h0;
        end else if (pin) begin
            high_cnt <= high_cnt + 32'h1;
        end
        if (pin !== last) begin
            gap   <= since + 32'h1;
            since <= 32'h0;
        end else begin
            since <= since + 32'h1;
        end
        last <= pin;
    end
endmodule
`default_nettype wire

// ===== dv/pwt_timer_tb_top.sv
// self-checking bench for the periodic pwm timer channel
`timescale 1ns/100ps
`default_nettype none
module pwt_timer_tb_top;
    import pwt_pkg::*;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, irq, pin_a, pin_b, clr;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd, per, gap, hcnt;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    logic [15:0] rnd;
    logic [3:0]  psc;
    int          fails, compares;

    pwt_timer DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq), .timer_output_pin_a(pin_a),
        .timer_output_pin_b(pin_b));
    pwt_pin_mon mon (.aclk(aclk), .pin(pin_a), .clr(clr), .gap(gap), .high_cnt(hcnt));

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [31:0] ctrl(input logic [1:0] md, input logic au,
        input logic ea, input logic [1:0] sa, input logic eb, input logic [1:0] sb,
        input logic [3:0] ps);
        return {19'h0, ps, sb, eb, sa, ea, au, md};
    endfunction

    // toggle spacing: period+1 ticks of 2**n clocks, n clamped at the maximum
    function automatic logic [31:0] exp_gap(input logic [31:0] p, input logic [3:0] s);
        return (p + 32'h1) << ((s > PWT_PRESC_MAX) ? PWT_PRESC_MAX : s);
    endfunction

    task automatic end_sim();
        if (fails == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
            fails++;
        end
    endtask

    task automatic give_up();
        fails++;
        end_sim();
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // aw and w are offered together and each dropped at its own handshake edge
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int  n;
        bit  ad, wd;
        ad = 0;
        wd = 0;
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hF;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 50 && !(ad && wd); n++) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wd = 1;
                wvalid <= 1'b0;
            end
        end
        if (!(ad && wd)) give_up();
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (bvalid) break;
        end
        if (n == 50) give_up();
        r = bresp;
        // ready lines stay high so back-to-back calls never lower and raise them at once
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) break;
        end
        if (n == 50) give_up();
        arvalid <= 1'b0;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (rvalid) break;
        end
        if (n == 50) give_up();
        d = rdata;
        r = rresp;
    endtask

    task automatic wait_irq();
        int n;
        for (n = 0; n < 3000; n++) begin
            @(posedge aclk);
            if (irq === 1'b1) break;
        end
        if (n == 3000) give_up();
    endtask

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, clr} = '0;
        awaddr  = 8'h00;
        araddr  = 8'h00;
        wdata   = 32'h0;
        wstrb   = 4'h0;
        fails   = 0;
        compares = 0;
        rnd     = 16'h0047;
        aresetn = 1'b0;
        cyc(2);
        aresetn <= 1'b1;
        cyc(1);
        chk("pin_a", pin_a, 0);
        axr(PWT_OFF_CTRL, rd, rs);
        chk("ctrl", rd, 32'h4);
        axr(PWT_OFF_STATUS, rd, rs);
        chk("status", rd, 32'h0);
        axr(8'h1C, rd, rs);
        chk("rresp", rs, PWT_RESP_SLVERR);
        axw(8'h20, 32'h1, rs);
        chk("bresp", rs, PWT_RESP_SLVERR);
        axr(PWT_OFF_CMD, rd, rs);
        chk("cmd", rd, 32'h0);
        rnd = lfsr(rnd);
        per = 32'h10 + {28'h0, rnd[3:0]};
        psc = {2'h0, rnd[7:6]};
        axw(PWT_OFF_MASK, 32'h1, rs);
        axw(PWT_OFF_PERIOD, per, rs);
        chk("bresp", rs, PWT_RESP_OKAY);
        axw(PWT_OFF_CTRL, ctrl(2'h0, 0, 1, 2'h0, 1, 2'h1, psc), rs);
        cyc(2);
        axr(PWT_OFF_STATUS, rd, rs);
        chk("running", rd[PWT_STS_RUN], 0);
        chk("pin_b", pin_b, 1);
        axw(PWT_OFF_CMD, 32'h1 << PWT_CMD_START, rs);
        for (int k = 1; k <= 3; k++) begin
            wait_irq();
            chk("irq", irq, 1);
            chk("pin_a", pin_a, k % 2);
            chk("pin_b", pin_b, 1 - k % 2);
            axw(PWT_OFF_STATUS, 32'h1, rs);
        end
        chk("gap", gap, exp_gap(per, psc));
        axw(PWT_OFF_CMD, 32'h1 << PWT_CMD_STOP, rs);
        cyc(2);
        chk("pin_a", pin_a, 0);
        chk("pin_b", pin_b, 1);
        // retained stop level, output b disabled, auto start on configure
        axw(PWT_OFF_CTRL, ctrl(2'h0, 1, 1, 2'h2, 0, 2'h1, 4'h0), rs);
        axr(PWT_OFF_STATUS, rd, rs);
        chk("running", rd[PWT_STS_RUN], 1);
        wait_irq();
        axw(PWT_OFF_STATUS, 32'h1, rs);
        axw(PWT_OFF_CMD, 32'h1 << PWT_CMD_STOP, rs);
        cyc(2);
        chk("pin_a", pin_a, 1);
        chk("pin_b", pin_b, 0);
        axw(PWT_OFF_CTRL, ctrl(2'h1, 0, 1, 2'h0, 0, 2'h0, 4'h0), rs);
        axw(PWT_OFF_CMD, 32'h1 << PWT_CMD_START, rs);
        cyc(2);
        chk("pin_a", pin_a, 1);
        wait_irq();
        chk("pin_a", pin_a, 0);
        axw(PWT_OFF_STATUS, 32'h1, rs);
        axw(PWT_OFF_CMD, 32'h1 << PWT_CMD_STOP, rs);
        axw(PWT_OFF_PERIOD, 32'd9, rs);
        axw(PWT_OFF_DUTY, 32'd3, rs);
        axw(PWT_OFF_CTRL, ctrl(2'h2, 0, 1, 2'h0, 1, 2'h0, 4'h0), rs);
        axr(PWT_OFF_CTRL, rd, rs);
        chk("ctrl", rd, ctrl(2'h2, 0, 1, 2'h0, 1, 2'h0, 4'h0));
        axw(PWT_OFF_CMD, 32'h1 << PWT_CMD_START, rs);
        cyc(20);
        clr <= 1'b1;
        cyc(1);
        clr <= 1'b0;
        // the count read at an edge excludes that edge, so 101 waits give 100 samples
        cyc(101);
        chk("high_cnt", hcnt, 32'h1E);
        // masked expiries still latch in status but leave irq low
        axw(PWT_OFF_MASK, 32'h0, rs);
        cyc(30);
        chk("irq", irq, 0);
        axr(PWT_OFF_STATUS, rd, rs);
        chk("expired", rd[PWT_STS_EXP], 1);
        axw(PWT_OFF_CMD, 32'h1 << PWT_CMD_STOP, rs);
        // reserved mode and stop codes, divider select above the clamp
        axw(PWT_OFF_STATUS, 32'h1, rs);
        axw(PWT_OFF_MASK, 32'h1, rs);
        axw(PWT_OFF_PERIOD, 32'h0, rs);
        axw(PWT_OFF_CTRL, ctrl(2'h3, 1, 1, 2'h0, 1, 2'h3, 4'hF), rs);
        wait_irq();
        chk("pin_a", pin_a, 1);
        chk("pin_b", pin_b, 1);
        axw(PWT_OFF_STATUS, 32'h1, rs);
        wait_irq();
        axw(PWT_OFF_CMD, 32'h1 << PWT_CMD_STOP, rs);
        cyc(2);
        chk("gap", gap, exp_gap(32'h0, 4'hF));
        chk("pin_b", pin_b, 0);
        end_sim();
    end
endmodule
`default_nettype wire
